/* File: design/bdmd_pkg.sv */
// Package for the banked data memory decoder
package bdmd_pkg;
    localparam int          ADDR_W         = 12;
    localparam int          DATA_W         = 8;
    localparam int          MEM_DEPTH      = 4096;
    localparam int          BANK_COUNT     = 16;
    localparam int          BANK_SIZE      = 256;
    localparam int          USER_BYTES     = 3936;
    localparam logic [11:0] SFR_LOW        = 12'hf5a;
    localparam logic [11:0] SFR_HIGH       = 12'hfff;
    localparam logic [11:0] GAP_LOW        = 12'hf40;
    localparam logic [11:0] GAP_HIGH       = 12'hf59;
    localparam logic [11:0] NOWIN_HIGH     = 12'hf5f;
    localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
    localparam logic [3:0]  SFR_BANK       = 4'hf;
    localparam logic [3:0]  GPR_BANK       = 4'h0;
    localparam logic [11:0] ADDR_WDT_CTRL  = 12'hfc0;
    localparam logic [11:0] ADDR_BANK_PTR  = 12'hfe0;
    localparam logic [11:0] ADDR_PMP_ADDRH = 12'hf69;
    localparam logic [11:0] ADDR_PMP_ADDRL = 12'hf68;
    localparam logic [11:0] ADDR_IND0      = 12'hfef;
    localparam logic [11:0] ADDR_IND0_END  = 12'hfeb;
    localparam logic [11:0] ADDR_IND1      = 12'hfe7;
    localparam logic [11:0] ADDR_IND1_END  = 12'hfe3;
    localparam logic [11:0] ADDR_IND2      = 12'hfdf;
    localparam logic [11:0] ADDR_IND2_END  = 12'hfdb;
    localparam logic [11:0] ADDR_UNUSED0   = 12'hfd4;
    localparam int          WDT_SLEEP_BIT  = 7;
    localparam int          WDT_LVD_BIT    = 6;
    localparam int          WDT_SHARE_BIT  = 4;
    localparam int          WDT_SWEN_BIT   = 0;
    localparam logic [7:0]  WDT_WR_MASK    = 8'h91;
    localparam logic [7:0]  BANK_PTR_MASK  = 8'h0f;
    localparam logic [7:0]  ZERO_BYTE      = 8'h00;
    localparam logic [7:0]  WDT_RESET      = 8'h00;
    localparam logic [3:0]  BANK_PTR_RESET = 4'h0;

    typedef enum logic [3:0] {
        BDMD_OP_NONE    = 4'b0001,
        BDMD_OP_BANKED  = 4'b0010,
        BDMD_OP_LOADBNK = 4'b0100,
        BDMD_OP_FULLMOV = 4'b1000
    } bdmd_op_t;

    typedef struct packed {
        bdmd_op_t    op;
        logic        use_access;
        logic [7:0]  offset;
        logic [11:0] src_full;
        logic [11:0] dst_full;
        logic        wr_en;
        logic [7:0]  wr_data;
        logic [7:0]  literal;
    } bdmd_req_t;
endpackage

/* File: design/bdmd_decode.sv */
// Banked data memory decoder with storage and bank pointer
`timescale 1ns/10ps
`default_nettype none
module bdmd_decode
    import bdmd_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire bdmd_req_t   REQ,
    input  wire logic        PMP_SLAVE_MODE,
    input  wire logic        LOW_VOLT_IN,
    output logic      [7:0]  RD_DATA,
    output logic      [11:0] EFF_ADDR,
    output logic             ACC_DONE,
    output logic             ACC_HIT,
    output logic      [3:0]  BANK_PTR,
    output logic             SHARE_SEL,
    output logic             SOFT_WDT_EN,
    output logic             REG_SLEEP
);
    // Main array plus alternate copies for shared-address slots
    logic [7:0]  mem_r [0:MEM_DEPTH-1];
    logic [7:0]  alt_mem_r [0:BANK_SIZE-1];
    logic [7:0]  pmp_out_r [0:1];
    logic [3:0]  bank_ptr_r;
    logic [7:0]  wdt_r;
    logic        lvd_r;
    logic [11:0] addr_nxt;
    logic [11:0] dst_nxt;
    logic        op_active;
    logic        wr_ok;
    logic [7:0]  rd_nxt;
    logic [7:0]  wr_byte;

    // Access window: low part to bank 0, upper part to bank 15
    function automatic logic [11:0] access_map(input logic [7:0] off);
        if (off < ACCESS_SPLIT) begin
            access_map = {GPR_BANK, off};
        end else begin
            access_map = {SFR_BANK, off};
        end
    endfunction

    // Implemented locations: everything except gap, unused slot, ports
    function automatic logic is_impl(input logic [11:0] a);
        logic hole;
        hole = 1'b0;
        if (a >= GAP_LOW && a <= GAP_HIGH) begin
            hole = 1'b1;
        end
        if (a == ADDR_UNUSED0) begin
            hole = 1'b1;
        end
        if ((a <= ADDR_IND0 && a >= ADDR_IND0_END)
            || (a <= ADDR_IND1 && a >= ADDR_IND1_END)
            || (a <= ADDR_IND2 && a >= ADDR_IND2_END)) begin
            hole = 1'b1;
        end
        is_impl = !hole;
    endfunction

    function automatic logic is_pmp(input logic [11:0] a);
        is_pmp = (a == ADDR_PMP_ADDRH) || (a == ADDR_PMP_ADDRL);
    endfunction

    assign op_active = (REQ.op == BDMD_OP_BANKED)
                     || (REQ.op == BDMD_OP_FULLMOV);

    // Address forming
    always_comb begin
        dst_nxt = REQ.dst_full;
        case (REQ.op)
            BDMD_OP_FULLMOV: begin
                addr_nxt = REQ.src_full;
            end
            BDMD_OP_BANKED: begin
                if (REQ.use_access) begin
                    addr_nxt = access_map(REQ.offset);
                end else begin
                    addr_nxt = {bank_ptr_r, REQ.offset};
                end
                dst_nxt = addr_nxt;
            end
            default: begin
                addr_nxt = {bank_ptr_r, REQ.offset};
            end
        endcase
    end

    // A full move stores the byte it read, not a bus operand
    assign wr_byte = (REQ.op == BDMD_OP_FULLMOV) ? rd_nxt : REQ.wr_data;

    // Window cannot reach F5Ah..F5Fh because split sits at 60h
    assign wr_ok = op_active && REQ.wr_en && is_impl(dst_nxt);

    // Read mux with special registers and shared slots
    always_comb begin
        rd_nxt = ZERO_BYTE;
        if (!is_impl(addr_nxt)) begin
            rd_nxt = ZERO_BYTE;
        end else if (addr_nxt == ADDR_BANK_PTR) begin
            rd_nxt = {4'h0, bank_ptr_r};
        end else if (addr_nxt == ADDR_WDT_CTRL) begin
            rd_nxt = wdt_r & WDT_WR_MASK;
            rd_nxt[WDT_LVD_BIT] = lvd_r;
        end else if (is_pmp(addr_nxt) && PMP_SLAVE_MODE) begin
            rd_nxt = pmp_out_r[addr_nxt[0]];
        end else if (wdt_r[WDT_SHARE_BIT]
                     && addr_nxt[11:8] == SFR_BANK) begin
            rd_nxt = alt_mem_r[addr_nxt[7:0]];
        end else begin
            rd_nxt = mem_r[addr_nxt];
        end
    end

    // Bank pointer, only four bits stored
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            bank_ptr_r <= BANK_PTR_RESET;
        end else if (REQ.op == BDMD_OP_LOADBNK) begin
            bank_ptr_r <= REQ.literal[3:0];
        end else if (wr_ok && dst_nxt == ADDR_BANK_PTR) begin
            bank_ptr_r <= wr_byte[3:0];
        end
    end

    // Watchdog/shared control, writable bits only
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wdt_r <= WDT_RESET;
        end else if (wr_ok && dst_nxt == ADDR_WDT_CTRL) begin
            wdt_r <= wr_byte & WDT_WR_MASK;
        end
    end

    // Low-voltage status follows its source, read-only
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            lvd_r <= 1'b0;
        end else begin
            lvd_r <= LOW_VOLT_IN;
        end
    end

    // Storage; no reset so it maps onto plain RAM
    always_ff @(posedge CLK) begin
        if (wr_ok && dst_nxt != ADDR_BANK_PTR
            && dst_nxt != ADDR_WDT_CTRL) begin
            if (is_pmp(dst_nxt) && PMP_SLAVE_MODE) begin
                pmp_out_r[dst_nxt[0]] <= wr_byte;
            end else if (wdt_r[WDT_SHARE_BIT]
                         && dst_nxt[11:8] == SFR_BANK) begin
                alt_mem_r[dst_nxt[7:0]] <= wr_byte;
            end else begin
                mem_r[dst_nxt] <= wr_byte;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RD_DATA  <= ZERO_BYTE;
            EFF_ADDR <= 12'h000;
            ACC_DONE <= 1'b0;
            ACC_HIT  <= 1'b0;
        end else begin
            RD_DATA  <= rd_nxt;
            EFF_ADDR <= addr_nxt;
            ACC_DONE <= op_active;
            ACC_HIT  <= op_active && is_impl(addr_nxt);
        end
    end

    assign BANK_PTR    = bank_ptr_r;
    assign SHARE_SEL   = wdt_r[WDT_SHARE_BIT];
    assign SOFT_WDT_EN = wdt_r[WDT_SWEN_BIT];
    assign REG_SLEEP   = wdt_r[WDT_SLEEP_BIT];

    a_bank_load: assert property (@(posedge CLK) disable iff (!RESET_N)
        REQ.op == BDMD_OP_LOADBNK |=> BANK_PTR == $past(REQ.literal[3:0]))
        else $error("bank pointer not loaded");
    a_bank_addr: assert property (@(posedge CLK) disable iff (!RESET_N)
        (REQ.op == BDMD_OP_BANKED && !REQ.use_access)
        |=> EFF_ADDR == {$past(bank_ptr_r), $past(REQ.offset)})
        else $error("banked address wrong");
    a_full_move: assert property (@(posedge CLK) disable iff (!RESET_N)
        REQ.op == BDMD_OP_FULLMOV |=> EFF_ADDR == $past(REQ.src_full))
        else $error("full move address wrong");
    a_gap_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
        (op_active && addr_nxt >= GAP_LOW && addr_nxt <= GAP_HIGH)
        |=> RD_DATA == ZERO_BYTE && !ACC_HIT)
        else $error("gap read not zero");
    a_done_always: assert property (@(posedge CLK) disable iff (!RESET_N)
        op_active |=> ACC_DONE)
        else $error("access not completed");
    a_window_map: assert property (@(posedge CLK) disable iff (!RESET_N)
        (REQ.op == BDMD_OP_BANKED && REQ.use_access)
        |=> EFF_ADDR[11:8] == (EFF_ADDR[7:0] < ACCESS_SPLIT ? 4'h0 : 4'hf)
            && !(EFF_ADDR >= SFR_LOW && EFF_ADDR <= NOWIN_HIGH))
        else $error("window mapping wrong");
    a_wdt_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
        (op_active && addr_nxt == ADDR_WDT_CTRL)
        |=> (RD_DATA & 8'h2e) == 8'h00)
        else $error("watchdog reserved bits set");
    a_bsr_upper: assert property (@(posedge CLK) disable iff (!RESET_N)
        (op_active && addr_nxt == ADDR_BANK_PTR)
        |=> RD_DATA[7:4] == 4'h0)
        else $error("bank pointer upper bits set");
    a_indirect_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
        (op_active && addr_nxt == ADDR_IND0) |=> RD_DATA == ZERO_BYTE)
        else $error("indirect port read not zero");

    // Multi-step checks, the first four built from named sequences
    sequence s_wdt_write;
        wr_ok && dst_nxt == ADDR_WDT_CTRL;
    endsequence
    sequence s_bank_write;
        wr_ok && dst_nxt == ADDR_BANK_PTR;
    endsequence
    sequence s_load_then_bank;
        REQ.op == BDMD_OP_LOADBNK
        ##1 (REQ.op == BDMD_OP_BANKED && !REQ.use_access);
    endsequence
    sequence s_window_low;
        REQ.op == BDMD_OP_BANKED && REQ.use_access
        && REQ.offset < ACCESS_SPLIT;
    endsequence

    a_wdt_write: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        s_wdt_write |=> SHARE_SEL == $past(wr_byte[WDT_SHARE_BIT])
            && SOFT_WDT_EN == $past(wr_byte[WDT_SWEN_BIT]))
        else $error("watchdog control not written");
    a_bank_write: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        s_bank_write |=> BANK_PTR == $past(wr_byte[3:0]))
        else $error("bank pointer write lost");
    a_load_use: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        s_load_then_bank |=> EFF_ADDR[11:8] == $past(REQ.literal[3:0], 2))
        else $error("loaded bank not used");
    a_window_low: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        s_window_low |=> EFF_ADDR[11:8] == GPR_BANK)
        else $error("window low part not in bank 0");
    a_unused_zero: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (op_active && addr_nxt == ADDR_UNUSED0)
        |=> RD_DATA == ZERO_BYTE && !ACC_HIT)
        else $error("unused slot read not zero");
    a_ind1_zero: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (op_active && addr_nxt == ADDR_IND1)
        |=> RD_DATA == ZERO_BYTE && !ACC_HIT)
        else $error("second indirect port read not zero");
    a_ind2_zero: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (op_active && addr_nxt == ADDR_IND2)
        |=> RD_DATA == ZERO_BYTE && !ACC_HIT)
        else $error("third indirect port read not zero");
    a_hit_flag: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (op_active && is_impl(addr_nxt)) |=> ACC_HIT)
        else $error("implemented access not flagged");
    a_idle_quiet: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        !op_active |=> !ACC_DONE && !ACC_HIT)
        else $error("idle cycle flagged as access");
    // Status bit is a plain one-cycle copy of its source
    a_lvd_follow: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        1'b1 |=> lvd_r == $past(LOW_VOLT_IN))
        else $error("low-voltage status not tracking");
endmodule // bdmd_decode
`default_nettype wire

/* File: sim/bdmd_cpu_model.sv */
// CPU-side request model for the data memory decoder
`timescale 1ns/10ps
`default_nettype none
module bdmd_cpu_model
    import bdmd_pkg::*;
(
    input  wire logic      CLK,
    output var  bdmd_req_t REQ
);
    bdmd_req_t idle_c;
    initial begin
        idle_c    = '0;
        idle_c.op = BDMD_OP_NONE;
        REQ       = idle_c;
    end
    // Idle after each op so every answer is seen on its own
    task automatic issue(input bdmd_req_t r);
        @(posedge CLK);
        REQ <= r;
        @(posedge CLK);
        REQ <= idle_c;
        #1;
    endtask
    task automatic banked(input logic a, input logic [7:0] off,
                          input logic we, input logic [7:0] wd);
        bdmd_req_t r;
        r            = idle_c;
        r.op         = BDMD_OP_BANKED;
        r.use_access = a;
        r.offset     = off;
        r.wr_en      = we;
        r.wr_data    = wd;
        issue(r);
    endtask
    task automatic fullmov(input logic [11:0] s, input logic [11:0] d);
        bdmd_req_t r;
        r          = idle_c;
        r.op       = BDMD_OP_FULLMOV;
        r.src_full = s;
        r.dst_full = d;
        r.wr_en    = 1'b1;
        issue(r);
    endtask
    task automatic loadbnk(input logic [7:0] lit);
        bdmd_req_t r;
        r         = idle_c;
        r.op      = BDMD_OP_LOADBNK;
        r.literal = lit;
        issue(r);
    endtask
endmodule // bdmd_cpu_model
`default_nettype wire

/* File: sim/tb_banked_data_memory_decode.sv */
// Self-checking bench for the banked data memory decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    n_mismatch++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_banked_data_memory_decode
    import bdmd_pkg::*;
;
    logic        CLK, RESET_N, PMP_SLAVE_MODE, LOW_VOLT_IN;
    bdmd_req_t   req;
    logic [7:0]  rd_data;
    logic [11:0] eff_addr;
    logic [3:0]  bank_ptr;
    logic        acc_done, acc_hit, share_sel, soft_wdt_en, reg_sleep;
    int          n_mismatch  = 0;
    int          comparisons = 0;
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    bdmd_cpu_model cpu_u (.CLK(CLK), .REQ(req));
    bdmd_decode dut_u (.CLK(CLK), .RESET_N(RESET_N), .REQ(req),
        .PMP_SLAVE_MODE(PMP_SLAVE_MODE), .LOW_VOLT_IN(LOW_VOLT_IN),
        .RD_DATA(rd_data), .EFF_ADDR(eff_addr), .ACC_DONE(acc_done),
        .ACC_HIT(acc_hit), .BANK_PTR(bank_ptr), .SHARE_SEL(share_sel),
        .SOFT_WDT_EN(soft_wdt_en), .REG_SLEEP(reg_sleep));
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // The done flag must still assert even when the target is absent
    task automatic look(input logic [11:0] a, input logic [7:0] d,
                        input logic h);
        `CHK("eff_addr", a, eff_addr)
        `CHK("rd_data", d, rd_data)
        `CHK("acc_hit", h, acc_hit)
        `CHK("acc_done", 1'b1, acc_done)
    endtask
    initial begin
        repeat (2000) @(posedge CLK);
        n_mismatch++;
        close_out();
    end
    initial begin
        RESET_N        = 1'b0;
        PMP_SLAVE_MODE = 1'b0;
        LOW_VOLT_IN    = 1'b0;
        repeat (6) @(posedge CLK);
        RESET_N     <= 1'b1;
        LOW_VOLT_IN <= 1'b1;
        @(posedge CLK);
        #1;
        `CHK("bank_ptr", 4'h0, bank_ptr)
        `CHK("share_sel", 1'b0, share_sel)
        cpu_u.loadbnk(8'ha5);
        `CHK("bank_ptr", 4'h5, bank_ptr)
        cpu_u.banked(1'b0, 8'h10, 1'b1, 8'h3c);
        cpu_u.banked(1'b0, 8'h10, 1'b0, 8'h00);
        look(12'h510, 8'h3c, 1'b1);
        cpu_u.fullmov(12'h510, 12'h020);
        look(12'h510, 8'h3c, 1'b1);
        cpu_u.banked(1'b1, 8'h20, 1'b0, 8'h00);
        look(12'h020, 8'h3c, 1'b1);
        cpu_u.banked(1'b1, 8'h60, 1'b1, 8'h77);
        cpu_u.banked(1'b1, 8'h60, 1'b0, 8'h00);
        look(12'hf60, 8'h77, 1'b1);
        cpu_u.fullmov(12'h510, 12'hf45);
        cpu_u.fullmov(12'hf45, 12'h511);
        look(12'hf45, 8'h00, 1'b0);
        cpu_u.fullmov(12'hfef, 12'h512);
        look(12'hfef, 8'h00, 1'b0);
        cpu_u.loadbnk(8'h0f);
        cpu_u.banked(1'b0, 8'h5a, 1'b1, 8'h66);
        cpu_u.banked(1'b0, 8'h5a, 1'b0, 8'h00);
        look(12'hf5a, 8'h66, 1'b1);
        cpu_u.banked(1'b1, 8'h5a, 1'b0, 8'h00);
        `CHK("eff_addr", 12'h05a, eff_addr)
        cpu_u.banked(1'b0, 8'hc0, 1'b1, 8'hff);
        cpu_u.banked(1'b0, 8'hc0, 1'b0, 8'h00);
        look(12'hfc0, 8'hd1, 1'b1);
        `CHK("wdt_en", 1'b1, soft_wdt_en)
        `CHK("sleep", 1'b1, reg_sleep)
        cpu_u.banked(1'b0, 8'h60, 1'b1, 8'h99);
        cpu_u.banked(1'b0, 8'h60, 1'b0, 8'h00);
        look(12'hf60, 8'h99, 1'b1);
        cpu_u.banked(1'b0, 8'hc0, 1'b1, 8'h00);
        cpu_u.banked(1'b0, 8'h60, 1'b0, 8'h00);
        look(12'hf60, 8'h77, 1'b1);
        cpu_u.banked(1'b0, 8'he0, 1'b1, 8'hff);
        cpu_u.banked(1'b0, 8'he0, 1'b0, 8'h00);
        look(12'hfe0, 8'h0f, 1'b1);
        cpu_u.banked(1'b0, 8'h68, 1'b1, 8'h11);
        @(posedge CLK);
        PMP_SLAVE_MODE <= 1'b1;
        cpu_u.banked(1'b0, 8'h68, 1'b1, 8'h22);
        cpu_u.banked(1'b0, 8'h68, 1'b0, 8'h00);
        look(12'hf68, 8'h22, 1'b1);
        @(posedge CLK);
        PMP_SLAVE_MODE <= 1'b0;
        cpu_u.banked(1'b0, 8'h68, 1'b0, 8'h00);
        look(12'hf68, 8'h11, 1'b1);
        close_out();
    end
endmodule // tb_banked_data_memory_decode
`default_nettype wire
